// ===== pkg/pctg_pkg.sv
// Constants for the PWM chopper and trip guard output stage.
// Functional notes
// - Chopper modulates incoming PWM with carrier when enabled.
// - Carrier from system clock, frequency and duty fields.
// - First pulse lasts 8 clocks times (code+1).
// - Sustaining pulses keep switch on after first.
// - Sustaining duty selectable 12.5% to 87.5%.
// - Chopper disabled passes both PWM signals unchanged.
// - Six fault inputs, active low, signal trips.
// - Select register picks which fault inputs count.
// - Low for one clock is accepted as fault.
// - Trip forces outputs asynchronously, even without clock.
// - Each input selectable as cycle or latched source.
// - Cycle trip applies action to outputs immediately.
// - Cycle trip sets flag, interrupts if enabled.
// - Cycle trip releases at counter zero if fault gone.
// - Cycle flag stays until software clears it.
// - Cleared cycle flag resets if fault persists.
// - Each output driven high, low, hi-z or unchanged.
// - Action codes: 00 hi-z, 01 high, 10 low, 11 none.
// - Latched trip holds until software clears it.
// - Software force acts like a pin trip.
// - Any fault input can raise trip interrupt.
// - No selection and no force passes outputs through.
// - Trip register writes need protected-write unlock.
package pctg_pkg;
  // ==========================================================
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_TRIP_SEL   = 8'h12;
  localparam logic [7:0] IDX_RSVD       = 8'h13;
  localparam logic [7:0] IDX_TRIP_ACT   = 8'h14;
  localparam logic [7:0] IDX_TRIP_IEN   = 8'h15;
  localparam logic [7:0] IDX_TRIP_FLG   = 8'h16;
  localparam logic [7:0] IDX_TRIP_CLR   = 8'h17;
  localparam logic [7:0] IDX_TRIP_FRC   = 8'h18;
  localparam logic [7:0] IDX_CHOP_CTL   = 8'h1E;
  // ==========================================================
  // Field positions.
  localparam int          SEL_CYC_LSB   = 0;
  localparam int          SEL_LAT_LSB   = 8;
  localparam int          ACT_A_LSB     = 0;
  localparam int          ACT_B_LSB     = 2;
  localparam int          FLG_INT       = 0;
  localparam int          FLG_CYC       = 1;
  localparam int          FLG_LAT       = 2;
  localparam int          CHP_EN        = 0;
  localparam int          CHP_WID_LSB   = 1;
  localparam int          CHP_FRQ_LSB   = 5;
  localparam int          CHP_DUT_LSB   = 8;
  // ==========================================================
  // Reset values and action codes.
  localparam logic [15:0] RST_SEL       = 16'h0000;
  localparam logic [15:0] RST_ACT       = 16'h0000;
  localparam logic [15:0] RST_IEN       = 16'h0000;
  localparam logic [15:0] RST_CHP       = 16'h0000;
  localparam logic [1:0]  ACT_HIZ       = 2'h0;
  localparam logic [1:0]  ACT_HIGH      = 2'h1;
  localparam logic [1:0]  ACT_LOW       = 2'h2;
  localparam logic [1:0]  ACT_NONE      = 2'h3;
  // ==========================================================
  // Timing: first pulse unit in system clocks, carrier phases.
  localparam logic [7:0]  FIRST_UNIT    = 8'h08;
  localparam logic [2:0]  DUTY_MAX      = 3'h6;
  localparam int          FAULT_N       = 6;
endpackage

// ===== src/pctg_chop.sv
// One chopper lane: first pulse timer and carrier gating.
`timescale 1ns/1ps
module pctg_chop (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       chop_en,
  input  wire logic [3:0] width_code,
  input  wire logic       carrier,
  input  wire logic       pwm_in,
  output logic            pwm_out
);
  logic       pwm_prev_q;
  logic [7:0] first_cnt_q;
  logic [7:0] first_len;

  // ==========================================================
  // First pulse length is 8 clocks for each step of the code.
  assign first_len = pctg_pkg::FIRST_UNIT * ({4'h0, width_code} + 8'h01);

  // A rising PWM edge restarts the timer; low PWM idles it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwm_prev_q  <= 1'b0;
      first_cnt_q <= 8'h00;
    end
    else
    begin
      pwm_prev_q <= pwm_in;
      if (pwm_in && !pwm_prev_q)
        first_cnt_q <= first_len - 8'h01;
      else if (!pwm_in)
        first_cnt_q <= 8'h00;
      else if (first_cnt_q != 8'h00)
        first_cnt_q <= first_cnt_q - 8'h01;
    end
  end

  // Output is registered so chopped edges stay glitch free.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pwm_out <= 1'b0;
    else if (!chop_en)
      pwm_out <= pwm_in;
    else
      pwm_out <= pwm_in && ((pwm_in && !pwm_prev_q) || first_cnt_q != 8'h00
                 || carrier);
  end
endmodule // pctg_chop

// ===== src/pctg_top.sv
// Chopper and trip guard for one PWM output pair, AXI4-Lite slave.
`timescale 1ns/1ps
module pctg_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        protected_write_unlock,
  input  wire logic        period_counter_zero,
  input  wire logic        pwm_in_a,
  input  wire logic        pwm_in_b,
  input  wire logic [5:0]  fault_input_n,
  output logic             pwm_output_a,
  output logic             pwm_output_a_oe,
  output logic             pwm_output_b,
  output logic             pwm_output_b_oe,
  output logic             trip_interrupt
);
  logic [15:0] sel_q, act_q, ien_q, chp_q;
  logic [2:0]  flg_q;
  logic        cyc_q, lat_q;
  logic [5:0]  flt_m_q, flt_s_q;
  logic [7:0]  aw_q, ar_q;
  logic        aw_ok_q, w_ok_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        wr_do;
  logic [7:0]  wr_idx, rd_idx;
  logic        trip_wr_ok;
  logic [15:0] clr_v, frc_v;
  logic        cyc_fault, lat_fault, cyc_evt, lat_evt;
  logic        async_hit, trip_on;
  logic [2:0]  div_q;
  logic [2:0]  phase_q;
  logic        carrier;
  logic        chop_a, chop_b;

  // ==========================================================
  // Helpers.
  // Byte address to index; misaligned addresses never match.
  function automatic logic [7:0] to_idx(input logic [7:0] a);
    to_idx = (a[1:0] == 2'h0) ? {2'h0, a[7:2]} : 8'hFF;
  endfunction

  // Mapped indices; the reserved gap reads zero but answers OKAY.
  function automatic logic mapped(input logic [7:0] i);
    mapped = (i >= pctg_pkg::IDX_TRIP_SEL && i <= pctg_pkg::IDX_TRIP_FRC)
             || i == pctg_pkg::IDX_CHOP_CTL;
  endfunction

  // Drive value for one pin: {level, enable}.
  function automatic logic [1:0] act_out(input logic [1:0] c,
                                         input logic       trip,
                                         input logic       pin);
    if (!trip)
      act_out = {pin, 1'b1};
    else
    begin
      unique case (c)
        pctg_pkg::ACT_HIZ:  act_out = 2'b00;
        pctg_pkg::ACT_HIGH: act_out = 2'b11;
        pctg_pkg::ACT_LOW:  act_out = 2'b01;
        pctg_pkg::ACT_NONE: act_out = {pin, 1'b1};
      endcase
    end
  endfunction

  // ==========================================================
  // AXI4-Lite write channel: address and data taken in any order.
  assign s_axi_awready = !aw_ok_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_ok_q && !s_axi_bvalid;
  assign wr_do         = aw_ok_q && w_ok_q && !s_axi_bvalid;
  assign wr_idx        = to_idx(aw_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ok_q <= 1'b0;
      w_ok_q  <= 1'b0;
      aw_q    <= 8'h00;
      w_q     <= 32'h0000_0000;
      ws_q    <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q    <= s_axi_awaddr;
        aw_ok_q <= 1'b1;
      end
      else if (wr_do)
        aw_ok_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q    <= s_axi_wdata;
        ws_q   <= s_axi_wstrb;
        w_ok_q <= 1'b1;
      end
      else if (wr_do)
        w_ok_q <= 1'b0;
    end
  end

  // Response one cycle after both halves are held.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end
    else if (wr_do)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(wr_idx) ? 2'h0 : 2'h2;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ==========================================================
  // AXI4-Lite read channel, data one cycle after the address.
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx        = to_idx(s_axi_araddr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(rd_idx) ? 2'h0 : 2'h2;
      unique case (rd_idx)
        pctg_pkg::IDX_TRIP_SEL: s_axi_rdata <= {16'h0000, sel_q};
        pctg_pkg::IDX_TRIP_ACT: s_axi_rdata <= {16'h0000, act_q};
        pctg_pkg::IDX_TRIP_IEN: s_axi_rdata <= {16'h0000, ien_q};
        pctg_pkg::IDX_TRIP_FLG: s_axi_rdata <= {29'h0000_0000, flg_q};
        pctg_pkg::IDX_CHOP_CTL: s_axi_rdata <= {16'h0000, chp_q};
        default:                s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================
  // Configuration registers; only the low two lanes hold bits.
  // Trip registers ignore writes while the unlock is not active.
  assign trip_wr_ok = wr_do && protected_write_unlock;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_q <= pctg_pkg::RST_SEL;
      act_q <= pctg_pkg::RST_ACT;
      ien_q <= pctg_pkg::RST_IEN;
      chp_q <= pctg_pkg::RST_CHP;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (ws_q[i] && trip_wr_ok && wr_idx == pctg_pkg::IDX_TRIP_SEL)
          sel_q[i*8 +: 8] <= w_q[i*8 +: 8];
        if (ws_q[i] && trip_wr_ok && wr_idx == pctg_pkg::IDX_TRIP_ACT)
          act_q[i*8 +: 8] <= w_q[i*8 +: 8];
        if (ws_q[i] && trip_wr_ok && wr_idx == pctg_pkg::IDX_TRIP_IEN)
          ien_q[i*8 +: 8] <= w_q[i*8 +: 8];
        if (ws_q[i] && wr_do && wr_idx == pctg_pkg::IDX_CHOP_CTL)
          chp_q[i*8 +: 8] <= w_q[i*8 +: 8];
      end
    end
  end

  // Clear and force are write-only strobes lasting one cycle.
  assign clr_v = (trip_wr_ok && ws_q[0] && wr_idx == pctg_pkg::IDX_TRIP_CLR)
                 ? w_q[15:0] : 16'h0000;
  assign frc_v = (trip_wr_ok && ws_q[0] && wr_idx == pctg_pkg::IDX_TRIP_FRC)
                 ? w_q[15:0] : 16'h0000;

  // ==========================================================
  // Fault pins pass two flip-flops before the clocked trip logic.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flt_m_q <= 6'h3F;
      flt_s_q <= 6'h3F;
    end
    else
    begin
      flt_m_q <= fault_input_n;
      flt_s_q <= flt_m_q;
    end
  end

  // Low selected pins count as faults, split by source kind.
  assign cyc_fault = |(~flt_s_q & sel_q[pctg_pkg::SEL_CYC_LSB +: 6]);
  assign lat_fault = |(~flt_s_q & sel_q[pctg_pkg::SEL_LAT_LSB +: 6]);
  assign cyc_evt   = cyc_fault || frc_v[pctg_pkg::FLG_CYC];
  assign lat_evt   = lat_fault || frc_v[pctg_pkg::FLG_LAT];

  // The raw pins also force the outputs with no clock involved.
  assign async_hit = |(~fault_input_n & (sel_q[pctg_pkg::SEL_CYC_LSB +: 6]
                     | sel_q[pctg_pkg::SEL_LAT_LSB +: 6]));

  // ==========================================================
  // Trip states; a new event wins over a release or a clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cyc_q <= 1'b0;
    else if (cyc_evt)
      cyc_q <= 1'b1;
    else if (period_counter_zero)
      cyc_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lat_q <= 1'b0;
    else if (lat_evt)
      lat_q <= 1'b1;
    else if (clr_v[pctg_pkg::FLG_LAT])
      lat_q <= 1'b0;
  end

  // Sticky flags; the interrupt flag collects enabled events.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flg_q <= 3'h0;
    else
    begin
      if (cyc_evt)
        flg_q[pctg_pkg::FLG_CYC] <= 1'b1;
      else if (clr_v[pctg_pkg::FLG_CYC])
        flg_q[pctg_pkg::FLG_CYC] <= 1'b0;
      if (lat_evt)
        flg_q[pctg_pkg::FLG_LAT] <= 1'b1;
      else if (clr_v[pctg_pkg::FLG_LAT])
        flg_q[pctg_pkg::FLG_LAT] <= 1'b0;
      if ((cyc_evt && ien_q[pctg_pkg::FLG_CYC]) || (lat_evt && ien_q[pctg_pkg::FLG_LAT]))
        flg_q[pctg_pkg::FLG_INT] <= 1'b1;
      else if (clr_v[pctg_pkg::FLG_INT])
        flg_q[pctg_pkg::FLG_INT] <= 1'b0;
    end
  end

  assign trip_interrupt = flg_q[pctg_pkg::FLG_INT];

  // ==========================================================
  // Carrier: eight phases, each 1 to 8 system clocks long.
  // The high phases number duty code plus one, 1/8 up to 7/8.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_q   <= 3'h0;
      phase_q <= 3'h0;
    end
    else if (div_q >= chp_q[pctg_pkg::CHP_FRQ_LSB +: 3])
    begin
      div_q   <= 3'h0;
      phase_q <= phase_q + 3'h1;
    end
    else
      div_q <= div_q + 3'h1;
  end

  // Code 7 is not a valid ratio and is held to 7/8.
  assign carrier = (phase_q <= ((chp_q[pctg_pkg::CHP_DUT_LSB +: 3] > pctg_pkg::DUTY_MAX)
                   ? pctg_pkg::DUTY_MAX : chp_q[pctg_pkg::CHP_DUT_LSB +: 3]));

  // ==========================================================
  // One chopper lane for each output.
  pctg_chop u_chop_a (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .chop_en    (chp_q[pctg_pkg::CHP_EN]),
    .width_code (chp_q[pctg_pkg::CHP_WID_LSB +: 4]),
    .carrier    (carrier),
    .pwm_in     (pwm_in_a),
    .pwm_out    (chop_a)
  );

  pctg_chop u_chop_b (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .chop_en    (chp_q[pctg_pkg::CHP_EN]),
    .width_code (chp_q[pctg_pkg::CHP_WID_LSB +: 4]),
    .carrier    (carrier),
    .pwm_in     (pwm_in_b),
    .pwm_out    (chop_b)
  );

  // ==========================================================
  // Trip forcing sits after the chopper, so it always wins.
  // This path is combinational to keep working without a clock.
  assign trip_on = cyc_q || lat_q || async_hit;
  assign {pwm_output_a, pwm_output_a_oe} =
    act_out(act_q[pctg_pkg::ACT_A_LSB +: 2], trip_on, chop_a);
  assign {pwm_output_b, pwm_output_b_oe} =
    act_out(act_q[pctg_pkg::ACT_B_LSB +: 2], trip_on, chop_b);

  // ==========================================================
  // Checks.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cyc_fault;
    cyc_fault;
  endsequence
  sequence s_tripped;
    cyc_q && flg_q[pctg_pkg::FLG_CYC];
  endsequence

  property p_cyc_sets;
    s_cyc_fault |=> s_tripped;
  endproperty
  a_cyc_sets: assert property (p_cyc_sets) else $error("cycle trip not set");

  property p_cyc_release;
    cyc_q && period_counter_zero && !cyc_evt |=> !cyc_q;
  endproperty
  a_cyc_release: assert property (p_cyc_release) else $error("no release");

  property p_flag_sticky;
    flg_q[pctg_pkg::FLG_CYC] && !clr_v[pctg_pkg::FLG_CYC] |=> flg_q[pctg_pkg::FLG_CYC];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_reset_flag;
    clr_v[pctg_pkg::FLG_CYC] && cyc_fault |=> flg_q[pctg_pkg::FLG_CYC];
  endproperty
  a_reset_flag: assert property (p_reset_flag) else $error("flag not reset");

  property p_lat_hold;
    lat_q && !clr_v[pctg_pkg::FLG_LAT] |=> lat_q;
  endproperty
  a_lat_hold: assert property (p_lat_hold) else $error("latched trip lost");

  property p_low_action;
    trip_on && act_q[1:0] == pctg_pkg::ACT_LOW |-> !pwm_output_a && pwm_output_a_oe;
  endproperty
  a_low_action: assert property (p_low_action) else $error("low action wrong");

  property p_hiz_action;
    trip_on && act_q[3:2] == pctg_pkg::ACT_HIZ |-> !pwm_output_b_oe;
  endproperty
  a_hiz_action: assert property (p_hiz_action) else $error("hi-z action wrong");

  property p_pass;
    !trip_on |-> pwm_output_a == chop_a && pwm_output_a_oe;
  endproperty
  a_pass: assert property (p_pass) else $error("pass-through broken");

  property p_locked;
    wr_do && !protected_write_unlock && wr_idx == pctg_pkg::IDX_TRIP_SEL
      |=> $stable(sel_q);
  endproperty
  a_locked: assert property (p_locked) else $error("locked write took");

  property p_bypass;
    !chp_q[pctg_pkg::CHP_EN] && $stable(chp_q) |=> chop_b == $past(pwm_in_b);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass broken");

  property p_force;
    frc_v[pctg_pkg::FLG_LAT] |=> lat_q ##0 flg_q[pctg_pkg::FLG_LAT];
  endproperty
  a_force: assert property (p_force) else $error("force ignored");
endmodule // pctg_top

// ===== bench/pctg_fault_gate.sv
// Partner model: six fault pin sources and the gate drivers on the output pair.
`timescale 1ns/1ps
module pctg_fault_gate (
  input  wire logic       aclk,
  input  wire logic [5:0] fault_req,
  input  wire logic       pwm_output_a,
  input  wire logic       pwm_output_a_oe,
  input  wire logic       pwm_output_b,
  input  wire logic       pwm_output_b_oe,
  output logic [5:0]      fault_input_n,
  output logic            line_a,
  output logic            line_b
);
  // ==========================================================
  // Fault sources
  // Pins move only on clock edges, so every low lasts at least one clock.
  initial fault_input_n = 6'h3F;
  always @(posedge aclk)
  begin
    fault_input_n <= ~fault_req;
  end
  // ==========================================================
  // Gate drivers
  // The driver inputs carry pull-downs, so a released pin reads low.
  assign line_a = pwm_output_a_oe ? pwm_output_a : 1'h0;
  assign line_b = pwm_output_b_oe ? pwm_output_b : 1'h0;
endmodule // pctg_fault_gate

// ===== bench/tb_pwm_chopper_and_trip_guard.sv
// Self-checking bench for the chopper and trip guard output stage.
`timescale 1ns/1ps
module tb_pwm_chopper_and_trip_guard;
  // ==========================================================
  // Addresses, codes and signals
  localparam logic [7:0] A_SEL = pctg_pkg::IDX_TRIP_SEL << 2;
  localparam logic [7:0] A_RSV = pctg_pkg::IDX_RSVD << 2;
  localparam logic [7:0] A_ACT = pctg_pkg::IDX_TRIP_ACT << 2;
  localparam logic [7:0] A_IEN = pctg_pkg::IDX_TRIP_IEN << 2;
  localparam logic [7:0] A_FLG = pctg_pkg::IDX_TRIP_FLG << 2;
  localparam logic [7:0] A_CLR = pctg_pkg::IDX_TRIP_CLR << 2;
  localparam logic [7:0] A_FRC = pctg_pkg::IDX_TRIP_FRC << 2;
  localparam logic [7:0] A_CHP = pctg_pkg::IDX_CHOP_CTL << 2;
  localparam logic [1:0] OK    = 2'h0;
  localparam logic [1:0] SLV   = 2'h2;
  localparam int         LIMIT = 20000;
  logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        protected_write_unlock = 1'h0, period_counter_zero = 1'h0;
  logic        pwm_in_a = 1'h0, pwm_in_b = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [5:0]  fault_req = 6'h00, fault_input_n;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        pwm_output_a, pwm_output_a_oe, pwm_output_b, pwm_output_b_oe;
  logic        trip_interrupt, line_a, line_b;
  int          fails = 0, checks_done = 0, cycles = 0;

  // ==========================================================
  // Design and partner
  pctg_top u_pctg_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .protected_write_unlock(protected_write_unlock),
    .period_counter_zero(period_counter_zero), .pwm_in_a(pwm_in_a), .pwm_in_b(pwm_in_b),
    .fault_input_n(fault_input_n), .pwm_output_a(pwm_output_a),
    .pwm_output_a_oe(pwm_output_a_oe), .pwm_output_b(pwm_output_b),
    .pwm_output_b_oe(pwm_output_b_oe), .trip_interrupt(trip_interrupt));
  pctg_fault_gate u_pctg_fault_gate (
    .aclk(aclk), .fault_req(fault_req), .pwm_output_a(pwm_output_a),
    .pwm_output_a_oe(pwm_output_a_oe), .pwm_output_b(pwm_output_b),
    .pwm_output_b_oe(pwm_output_b_oe), .fault_input_n(fault_input_n),
    .line_a(line_a), .line_b(line_b));

  // ==========================================================
  // Clock and watchdog
  // The clock toggles every 12.5 ns, half of its 25 ns period.
  initial forever #12.5 aclk = ~aclk;
  // A hung handshake would stall the run, so a cycle ceiling cuts it short.
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      fails = fails + 1;
      complete_run();
    end
  end

  // ==========================================================
  // Helpers
  // Closing report and verdict.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One comparison, counted, reported at once on a mismatch.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Write: address and data offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_p, w_p;
    aw_p = 1'h1;
    w_p = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (aw_p || w_p)
    begin
      @(posedge aclk);
      if (aw_p && s_axi_awready === 1'h1)
      begin
        aw_p = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w_p && s_axi_wready === 1'h1)
      begin
        w_p = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    // Raised only once both halves are taken, so back-to-back calls never touch it twice.
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  // Read with a mask, so that bits left open by the map are not judged.
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m,
                    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk("rdata", ed & m, s_axi_rdata & m);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  // One-cycle period counter zero pulse.
  task automatic zpulse();
    period_counter_zero <= 1'h1;
    cyc(1);
    period_counter_zero <= 1'h0;
    cyc(2);
  endtask
  // Pins as {oe_a, line_a, oe_b, line_b}.
  task automatic outs(input logic [3:0] e);
    chk("pins", {28'h0, e}, {28'h0, pwm_output_a_oe, line_a, pwm_output_b_oe, line_b});
  endtask
  // Counts high cycles on output A.
  task automatic cnt_hi(input int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(posedge aclk);
      k += (line_a === 1'h1);
    end
  endtask
  // Expected {oe, line} for an action code and the incoming level.
  function automatic logic [1:0] act_exp(input logic [1:0] c, input logic p);
    case (c)
      pctg_pkg::ACT_HIZ:  return 2'h0;
      pctg_pkg::ACT_HIGH: return 2'h3;
      pctg_pkg::ACT_LOW:  return 2'h2;
      default:            return {1'h1, p};
    endcase
  endfunction

  // ==========================================================
  // Test sequence
  initial
  begin : main
    logic [1:0] c;
    int         k, w;
    cyc(16);
    aresetn <= 1'h1;
    rd(A_SEL, {16'h0, pctg_pkg::RST_SEL}, 32'hFFFF, OK);
    rd(A_ACT, {16'h0, pctg_pkg::RST_ACT}, 32'hFFFF, OK);
    rd(A_IEN, {16'h0, pctg_pkg::RST_IEN}, 32'hFFFF, OK);
    rd(A_CHP, {16'h0, pctg_pkg::RST_CHP}, 32'hFFFF, OK);
    rd(A_FLG, 32'h0, 32'h7, OK);
    rd(A_RSV, 32'h0, 32'hFFFFFFFF, OK);
    rd(8'h00, 32'h0, 32'hFFFFFFFF, SLV);
    rd(A_SEL + 8'h01, 32'h0, 32'hFFFFFFFF, SLV);
    wr(8'hFC, 32'h1, SLV);
    // Locked writes must not land.
    wr(A_SEL, 32'h1, OK);
    rd(A_SEL, 32'h0, 32'hFFFF, OK);
    protected_write_unlock <= 1'h1;
    // Nothing selected: low pins change nothing, bypassed chopper passes levels.
    pwm_in_a <= 1'h1;
    fault_req <= 6'h3F;
    cyc(4);
    outs(4'hE);
    fault_req <= 6'h00;
    // Every action code on both outputs, with both incoming levels.
    wr(A_SEL, 32'h1, OK);
    for (int i = 0; i < 8; i++)
    begin
      c = i[1:0];
      pwm_in_a <= i[2];
      pwm_in_b <= ~i[2];
      wr(A_ACT, {28'h0, ~c, c}, OK);
      fault_req <= 6'h01;
      cyc(2);
      outs({act_exp(c, i[2]), act_exp(~c, ~i[2])});
      fault_req <= 6'h00;
      cyc(4);
      outs({act_exp(c, i[2]), act_exp(~c, ~i[2])});
      zpulse();
      outs({1'h1, i[2], 1'h1, ~i[2]});
    end
    // Cycle flag, interrupt, re-set while the fault stays.
    wr(A_CLR, 32'h7, OK);
    wr(A_IEN, 32'h2, OK);
    wr(A_SEL, 32'h20, OK);
    fault_req <= 6'h20;
    cyc(5);
    chk("irq", 32'h1, {31'h0, trip_interrupt});
    rd(A_FLG, 32'h3, 32'h7, OK);
    wr(A_CLR, 32'h2, OK);
    rd(A_FLG, 32'h2, 32'h2, OK);
    fault_req <= 6'h00;
    cyc(4);
    zpulse();
    rd(A_FLG, 32'h2, 32'h2, OK);
    wr(A_CLR, 32'h7, OK);
    rd(A_FLG, 32'h0, 32'h7, OK);
    chk("irq", 32'h0, {31'h0, trip_interrupt});
    // A one-clock latched fault holds until cleared; its interrupt is disabled.
    wr(A_SEL, 32'h100, OK);
    wr(A_ACT, 32'hA, OK);
    pwm_in_a <= 1'h1;
    pwm_in_b <= 1'h1;
    fault_req <= 6'h01;
    cyc(1);
    fault_req <= 6'h00;
    cyc(4);
    outs(4'hA);
    zpulse();
    outs(4'hA);
    rd(A_FLG, 32'h4, 32'h7, OK);
    wr(A_CLR, 32'h4, OK);
    cyc(2);
    outs(4'hF);
    // Software force of both kinds.
    wr(A_SEL, 32'h0, OK);
    wr(A_FRC, 32'h2, OK);
    outs(4'hA);
    rd(A_FLG, 32'h2, 32'h6, OK);
    zpulse();
    outs(4'hF);
    wr(A_FRC, 32'h4, OK);
    zpulse();
    outs(4'hA);
    rd(A_FLG, 32'h6, 32'h6, OK);
    wr(A_CLR, 32'h7, OK);
    cyc(2);
    outs(4'hF);
    // Chopper: whole carrier periods after the first pulse make the count phase-free.
    pwm_in_a <= 1'h0;
    for (int i = 0; i < 8; i++)
    begin
      w = (i * 5) % 16;
      wr(A_CHP, {21'h0, i[2:0], i[2:0], w[3:0], 1'h1}, OK);
      cyc(4);
      pwm_in_a <= 1'h1;
      cyc(1);
      cnt_hi(8 * (w + 1) + 64 * (i + 1), k);
      chk("chop_high", 8 * (w + 1) + 8 * (i + 1) * ((i > 6 ? 6 : i) + 1), k);
      pwm_in_a <= 1'h0;
      cyc(2);
      cnt_hi(16, k);
      chk("chop_low", 32'h0, k);
    end
    // A trip forcing low wins over the chopped waveform.
    wr(A_SEL, 32'h1, OK);
    wr(A_ACT, 32'hE, OK);
    pwm_in_a <= 1'h1;
    fault_req <= 6'h01;
    cyc(2);
    cnt_hi(64, k);
    chk("trip_over_chop", 32'h0, k);
    complete_run();
  end
endmodule // tb_pwm_chopper_and_trip_guard
